//--- inc/ram_cmd_pkg.sv
// Command codes, field layouts, reset values and limits of the display RAM command block
package ram_cmd_pkg;
	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_WRITE = 8'h5C;
	localparam logic [7:0] CMD_READ = 8'h5D;
	localparam logic [7:0] CMD_RMW = 8'hE0;
	localparam logic [7:0] CMD_SCROLL = 8'hAA;
	localparam logic [7:0] CMD_START_LINE = 8'hAB;
	localparam logic [7:0] CMD_PART_IN = 8'hA8;
	localparam logic [7:0] CMD_PART_OUT = 8'hA9;
	localparam logic [7:0] CMD_IF = 8'h31;
	localparam logic [7:0] CMD_START_ADDR = 8'h15;
	localparam logic [7:0] CMD_END_ADDR = 8'h75;
	// ==========================================================
	// Parameter byte counts
	localparam logic [2:0] NP_SCROLL = 3'h4;
	localparam logic [2:0] NP_PART = 3'h3;
	localparam logic [2:0] NP_PAIR = 3'h2;
	// ==========================================================
	// RAM geometry and window reset values
	localparam int PIX_W = 18;
	localparam logic [7:0] COL_MAX = 8'hAF;
	localparam logic [7:0] ROW_MAX = 8'hDB;
	localparam logic [15:0] NUM_COLS = 16'h00B0;
	localparam logic [15:0] RAM_WORDS = 16'h9740;
	localparam logic [7:0] RST_START = 8'h00;
	localparam logic [7:0] RST_END_COL = COL_MAX;
	localparam logic [7:0] RST_END_ROW = ROW_MAX;
	// ==========================================================
	// Interface setup byte fields
	localparam int IF_MODE_LSB = 0;
	localparam int IF_EDGE_BIT = 3;
	localparam int IF_WIDTH_LSB = 4;
	localparam int IF_DE_POL_BIT = 6;
	localparam int IF_SYNC_POL_BIT = 7;
	localparam int DRIVE_BIT = 7;
	localparam logic [2:0] MODE_INTERNAL = 3'h0;
	localparam logic [2:0] MODE_HOST = 3'h1;
	localparam logic [2:0] MODE_FRAME_SYNC = 3'h3;
	localparam logic [1:0] MODE_BAD_LOW = 2'h2;
	localparam logic [1:0] WIDTH_18 = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_6 = 2'h2;
	localparam logic [1:0] WIDTH_BAD = 2'h3;
	// ==========================================================
	// Scroll modes and refresh
	localparam logic [1:0] SCROLL_CENTRE = 2'h0;
	localparam logic [1:0] SCROLL_TOP = 2'h1;
	localparam logic [1:0] SCROLL_BOTTOM = 2'h2;
	localparam logic [1:0] SCROLL_FULL = 2'h3;
	localparam logic [6:0] NO_REFRESH = 7'h7F;
	localparam logic [1:0] BUF_DEPTH = 2'h2;
endpackage

//--- hw/ram_cmd_ctrl.sv
// Display RAM command interpreter: pixel streaming, scroll, partial display, RGB interface
// Summary of operation
// - Pixel write loads pointers to window start, stores and advances per write
// - Writes accepted until next command; pointer wraps from window end to start
// - Pixel read restarts at window start, returns data, advances and wraps
// - In read-modify-write reads hold the address, writes store and advance
// - Any new command ends read-modify-write and returns pointer to start address
// - Area scroll setup takes start line, end line, line count and mode
// - Scroll mode: 00 centre, 01 top, 10 bottom, 11 whole screen
// - Display start line follows scroll start until start line command arrives
// - Host sets line count; device ignores it in bottom and full modes
// - Scrolling is active only after both setup and start line commands
// - Start line command takes one byte; repeating it scrolls dynamically
// - Partial entry takes three bytes; start and end are panel lines minus one
// - Code k refreshes non-display area every 2k+1 frames; all ones never
// - Top bit of third byte picks rail level or end grey level drive
// - Partial exit restores full display from the next frame
// - Interface command takes setup and divider bytes, applied on receipt
// - Transfer mode decode; pattern x10 is refused
// - Edge select: 0 samples RGB on rising, 1 on falling pixel clock
// - RGB width 00 18-bit, 01 16-bit, 10 6-bit in three steps; 11 refused
// - Polarity bits make enable and syncs active low at 0, high at 1
// - Pixel clock divided by value plus one; divider restarts each line
// - Window column spans 00..AF and row 00..DB
`timescale 1ns/1ps
module ram_cmd_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Host command and data stream
	input wire logic host_valid,
	output logic host_ready,
	input wire logic host_is_cmd,
	input wire logic host_is_read,
	input wire logic [ram_cmd_pkg::PIX_W-1:0] host_wdata,
	// Read data towards host
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [ram_cmd_pkg::PIX_W-1:0] rd_data,
	// RGB video source
	input wire logic pixel_clock,
	input wire logic data_enable,
	input wire logic line_sync_input,
	input wire logic frame_sync_input,
	input wire logic [ram_cmd_pkg::PIX_W-1:0] rgb_data,
	// Display timing
	input wire logic frame_start,
	output logic divided_clock_tick,
	// Scroll state
	output logic [7:0] scroll_start,
	output logic [7:0] scroll_end,
	output logic [7:0] scroll_lines_eff,
	output logic [1:0] scroll_mode,
	output logic [7:0] display_start_line,
	output logic scroll_active,
	// Partial display state
	output logic partial_on,
	output logic [7:0] partial_start,
	output logic [7:0] partial_end,
	output logic nondisplay_refresh,
	output logic nondisplay_hiz,
	output logic nondisplay_drive_select,
	// Interface setup
	output logic [2:0] transfer_mode,
	output logic clock_edge_select,
	output logic [1:0] rgb_width,
	output logic data_enable_polarity,
	output logic sync_polarity,
	output logic [2:0] pixel_clock_div,
	output logic if_setting_refused
);
	import ram_cmd_pkg::*;

	typedef enum logic [2:0] {PH_IDLE, PH_PARAM, PH_WRITE, PH_READ, PH_RMW} phase_e;

	typedef struct packed {
		phase_e phase;
		logic [7:0] cmd;
		logic [2:0] pidx;
		logic [7:0] start_col;
		logic [7:0] start_row;
		logic [7:0] end_col;
		logic [7:0] end_row;
		logic [7:0] col;
		logic [7:0] row;
		logic [7:0] sc_start;
		logic [7:0] sc_end;
		logic [7:0] sc_lines;
		logic [1:0] sc_mode;
		logic setup_seen;
		logic line_seen;
		logic [7:0] disp_line;
		logic [7:0] part_start;
		logic [7:0] part_end;
		logic [6:0] refresh_code;
		logic drive_sel;
		logic part_req;
		logic part_tgt;
		logic part_on;
		logic [7:0] frame_cnt;
		logic [2:0] if_mode;
		logic edge_sel;
		logic [1:0] width;
		logic de_pol;
		logic sync_pol;
		logic [2:0] dot_div;
		logic if_err;
		logic pclk_q;
		logic hs_q;
		logic [2:0] div_cnt;
		logic div_tick;
		logic [1:0] step;
		logic [11:0] acc;
		logic [15:0] rgb_addr;
		logic [PIX_W-1:0] buf0;
		logic [PIX_W-1:0] buf1;
		logic [1:0] cnt;
	} st_s;

	st_s s_r;
	st_s s_nxt;
	logic [PIX_W-1:0] mem [0:RAM_WORDS-1];
	logic mem_we;
	logic [15:0] mem_waddr;
	logic [PIX_W-1:0] mem_wdata;
	logic xfer;
	logic rgb_we;
	logic [PIX_W-1:0] rgb_pix;
	logic pclk_edge;
	logic [7:0] hb;

	// ==========================================================
	// Helpers
	function automatic logic [15:0] ram_index(input logic [7:0] c, input logic [7:0] r);
		ram_index = 16'(16'(r) * NUM_COLS) + 16'(c);
	endfunction

	function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lim);
		clamp = (v > lim) ? lim : v;
	endfunction

	// Column-first stepping, wrapping inside the window
	function automatic logic [15:0] step_ptr(input st_s s);
		logic [7:0] c;
		logic [7:0] r;
		c = s.col + 8'h01;
		r = s.row;
		if (s.col >= s.end_col) begin
			c = s.start_col;
			r = (s.row >= s.end_row) ? s.start_row : s.row + 8'h01;
		end
		step_ptr = {r, c};
	endfunction

	// ==========================================================
	// RGB capture on the selected pixel clock edge
	always_comb begin
		pclk_edge = s_r.edge_sel ? (s_r.pclk_q & ~pixel_clock) : (~s_r.pclk_q & pixel_clock);
		rgb_pix = rgb_data;
		rgb_we = 1'b0;
		if (s_r.if_mode[2] && pclk_edge && (data_enable == s_r.de_pol)) begin
			unique case (s_r.width)
				WIDTH_18: rgb_we = 1'b1;
				WIDTH_16: begin
					rgb_we = 1'b1;
					rgb_pix = {rgb_data[15:11], rgb_data[15], rgb_data[10:0], rgb_data[4]};
				end
				WIDTH_6: begin
					rgb_we = (s_r.step == 2'h2);
					rgb_pix = {s_r.acc, rgb_data[5:0]};
				end
				default: rgb_we = 1'b0;
			endcase
		end
	end

	assign host_ready = (s_r.cnt != BUF_DEPTH) && !rgb_we;
	assign xfer = host_valid && host_ready;
	assign hb = host_wdata[7:0];

	// ==========================================================
	// Next state
	always_comb begin
		logic pop;
		logic push;
		logic [PIX_W-1:0] pdata;
		logic [15:0] nx;
		pop = rd_ready && (s_r.cnt != 2'h0);
		push = 1'b0;
		pdata = mem[ram_index(s_r.col, s_r.row)];
		nx = step_ptr(s_r);
		s_nxt = s_r;
		mem_we = 1'b0;
		mem_waddr = ram_index(s_r.col, s_r.row);
		mem_wdata = host_wdata;
		s_nxt.div_tick = 1'b0;
		s_nxt.pclk_q = pixel_clock;
		s_nxt.hs_q = (line_sync_input == s_r.sync_pol);
		// Divided pixel clock, restarted at each line start
		if ((line_sync_input == s_r.sync_pol) && !s_r.hs_q) begin
			s_nxt.div_cnt = 3'h0;
		end else if (pclk_edge) begin
			s_nxt.div_cnt = (s_r.div_cnt == s_r.dot_div) ? 3'h0 : s_r.div_cnt + 3'h1;
			s_nxt.div_tick = (s_r.div_cnt == s_r.dot_div);
		end
		// RGB stream
		if (frame_sync_input == s_r.sync_pol) begin
			s_nxt.rgb_addr = 16'h0000;
			s_nxt.step = 2'h0;
		end else if (s_r.if_mode[2] && pclk_edge && (data_enable == s_r.de_pol)) begin
			if (s_r.width == WIDTH_6) begin
				s_nxt.step = (s_r.step == 2'h2) ? 2'h0 : s_r.step + 2'h1;
				if (s_r.step == 2'h0) s_nxt.acc[11:6] = rgb_data[5:0];
				if (s_r.step == 2'h1) s_nxt.acc[5:0] = rgb_data[5:0];
			end
			if (rgb_we) begin
				s_nxt.rgb_addr = (s_r.rgb_addr == RAM_WORDS - 16'h0001) ? 16'h0000 :
					s_r.rgb_addr + 16'h0001;
			end
		end
		if (rgb_we) begin
			mem_we = 1'b1;
			mem_waddr = s_r.rgb_addr;
			mem_wdata = rgb_pix;
		end
		// Frame boundary: pending partial change and refresh divider
		if (frame_start) begin
			if (s_r.part_req) begin
				s_nxt.part_on = s_r.part_tgt;
				s_nxt.part_req = 1'b0;
				s_nxt.frame_cnt = 8'h00;
			end else begin
				s_nxt.frame_cnt = (s_r.frame_cnt >= {s_r.refresh_code, 1'b0}) ? 8'h00 :
					s_r.frame_cnt + 8'h01;
			end
		end
		// Host command or data
		if (xfer && host_is_cmd) begin
			s_nxt.cmd = hb;
			s_nxt.pidx = 3'h0;
			s_nxt.col = s_r.start_col;
			s_nxt.row = s_r.start_row;
			unique case (hb)
				CMD_WRITE: s_nxt.phase = PH_WRITE;
				CMD_READ: s_nxt.phase = PH_READ;
				CMD_RMW: s_nxt.phase = PH_RMW;
				CMD_SCROLL, CMD_START_LINE, CMD_PART_IN, CMD_IF, CMD_START_ADDR,
				CMD_END_ADDR: s_nxt.phase = PH_PARAM;
				CMD_PART_OUT: begin
					s_nxt.phase = PH_IDLE;
					s_nxt.part_req = 1'b1;
					s_nxt.part_tgt = 1'b0;
				end
				default: s_nxt.phase = PH_IDLE;
			endcase
		end else if (xfer && host_is_read) begin
			push = 1'b1;
			if (s_r.phase == PH_READ) begin
				s_nxt.col = nx[7:0];
				s_nxt.row = nx[15:8];
			end else if (s_r.phase != PH_RMW) begin
				pdata = '0;
			end
		end else if (xfer) begin
			unique case (s_r.phase)
				PH_WRITE, PH_RMW: begin
					mem_we = 1'b1;
					s_nxt.col = nx[7:0];
					s_nxt.row = nx[15:8];
				end
				PH_PARAM: begin
					s_nxt.pidx = s_r.pidx + 3'h1;
					unique case (s_r.cmd)
						CMD_SCROLL: begin
							if (s_r.pidx == 3'h0) begin
								s_nxt.sc_start = hb;
								if (!s_r.line_seen) s_nxt.disp_line = hb;
							end
							if (s_r.pidx == 3'h1) s_nxt.sc_end = hb;
							if (s_r.pidx == 3'h2) s_nxt.sc_lines = hb;
							if (s_r.pidx == NP_SCROLL - 3'h1) begin
								s_nxt.sc_mode = hb[1:0];
								s_nxt.setup_seen = 1'b1;
							end
						end
						CMD_START_LINE: begin
							if (s_r.pidx == 3'h0) begin
								s_nxt.disp_line = hb;
								s_nxt.line_seen = 1'b1;
							end
						end
						CMD_PART_IN: begin
							if (s_r.pidx == 3'h0) s_nxt.part_start = hb;
							if (s_r.pidx == 3'h1) s_nxt.part_end = hb;
							if (s_r.pidx == NP_PART - 3'h1) begin
								s_nxt.refresh_code = hb[6:0];
								s_nxt.drive_sel = hb[DRIVE_BIT];
								s_nxt.part_req = 1'b1;
								s_nxt.part_tgt = 1'b1;
							end
						end
						CMD_IF: begin
							if (s_r.pidx == 3'h0) begin
								s_nxt.if_err = (hb[IF_MODE_LSB+:2] == MODE_BAD_LOW) ||
									(hb[IF_WIDTH_LSB+:2] == WIDTH_BAD);
								if (!s_nxt.if_err) begin
									s_nxt.if_mode = hb[IF_MODE_LSB+:3];
									s_nxt.edge_sel = hb[IF_EDGE_BIT];
									s_nxt.width = hb[IF_WIDTH_LSB+:2];
									s_nxt.de_pol = hb[IF_DE_POL_BIT];
									s_nxt.sync_pol = hb[IF_SYNC_POL_BIT];
								end
							end
							if (s_r.pidx == NP_PAIR - 3'h1) s_nxt.dot_div = hb[2:0];
						end
						CMD_START_ADDR: begin
							if (s_r.pidx == 3'h0) s_nxt.start_col = clamp(hb, COL_MAX);
							if (s_r.pidx == 3'h1) s_nxt.start_row = clamp(hb, ROW_MAX);
						end
						CMD_END_ADDR: begin
							if (s_r.pidx == 3'h0) s_nxt.end_col = clamp(hb, COL_MAX);
							if (s_r.pidx == 3'h1) s_nxt.end_row = clamp(hb, ROW_MAX);
						end
						default: s_nxt.pidx = s_r.pidx;
					endcase
				end
				default: s_nxt.phase = s_r.phase;
			endcase
		end
		// Two-entry read buffer
		if (pop) begin
			s_nxt.buf0 = s_r.buf1;
			s_nxt.cnt = s_r.cnt - 2'h1;
		end
		if (push) begin
			if (s_nxt.cnt == 2'h0) s_nxt.buf0 = pdata;
			else s_nxt.buf1 = pdata;
			s_nxt.cnt = s_nxt.cnt + 2'h1;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.phase <= PH_IDLE;
			s_r.end_col <= RST_END_COL;
			s_r.end_row <= RST_END_ROW;
			s_r.start_col <= RST_START;
			s_r.start_row <= RST_START;
			s_r.refresh_code <= NO_REFRESH;
			s_r.if_mode <= MODE_INTERNAL;
		end else begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
	end

	// ==========================================================
	// Outputs
	assign rd_valid = (s_r.cnt != 2'h0);
	assign rd_data = s_r.buf0;
	assign divided_clock_tick = s_r.div_tick;
	assign scroll_start = s_r.sc_start;
	assign scroll_end = s_r.sc_end;
	assign scroll_lines_eff = s_r.sc_mode[1] ? 8'h00 : s_r.sc_lines;
	assign scroll_mode = s_r.sc_mode;
	assign display_start_line = s_r.disp_line;
	assign scroll_active = s_r.setup_seen && s_r.line_seen;
	assign partial_on = s_r.part_on;
	assign partial_start = s_r.part_start;
	assign partial_end = s_r.part_end;
	assign nondisplay_refresh = s_r.part_on && (s_r.refresh_code != NO_REFRESH) &&
		(s_r.frame_cnt == 8'h00);
	assign nondisplay_hiz = s_r.part_on && !nondisplay_refresh;
	assign nondisplay_drive_select = s_r.drive_sel;
	assign transfer_mode = s_r.if_mode;
	assign clock_edge_select = s_r.edge_sel;
	assign rgb_width = s_r.width;
	assign data_enable_polarity = s_r.de_pol;
	assign sync_polarity = s_r.sync_pol;
	assign pixel_clock_div = s_r.dot_div;
	assign if_setting_refused = s_r.if_err;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_cmd_loads_start;
		xfer && host_is_cmd |=> s_r.col == $past(s_r.start_col) && s_r.row == $past(s_r.start_row);
	endproperty
	a_cmd_loads_start: assert property (p_cmd_loads_start) else $error("pointer not at start");

	property p_write_wrap;
		xfer && !host_is_cmd && !host_is_read && s_r.phase == PH_WRITE &&
			s_r.col == s_r.end_col && s_r.row == s_r.end_row
			|=> s_r.col == s_r.start_col && s_r.row == s_r.start_row;
	endproperty
	a_write_wrap: assert property (p_write_wrap) else $error("write did not wrap");

	property p_read_advance;
		xfer && host_is_read && s_r.phase == PH_READ && s_r.col < s_r.end_col
			|=> s_r.col == $past(s_r.col) + 8'h01;
	endproperty
	a_read_advance: assert property (p_read_advance) else $error("read did not advance");

	property p_rmw_hold;
		xfer && host_is_read && s_r.phase == PH_RMW |=> $stable(s_r.col) && $stable(s_r.row);
	endproperty
	a_rmw_hold: assert property (p_rmw_hold) else $error("rmw read moved pointer");

	property p_scroll_mode;
		xfer && !host_is_cmd && s_r.phase == PH_PARAM && s_r.cmd == CMD_SCROLL &&
			s_r.pidx == 3'h3 |=> scroll_mode == $past(hb[1:0]) ##1 $stable(scroll_mode)[*1];
	endproperty
	a_scroll_mode: assert property (p_scroll_mode) else $error("scroll mode not taken");

	property p_lines_ignored;
		scroll_mode == SCROLL_BOTTOM || scroll_mode == SCROLL_FULL |-> scroll_lines_eff == 8'h00;
	endproperty
	a_lines_ignored: assert property (p_lines_ignored) else $error("line count used");

	property p_part_waits_frame;
		s_r.part_req && !frame_start |=> $stable(partial_on);
	endproperty
	a_part_waits_frame: assert property (p_part_waits_frame) else $error("partial early");

	property p_if_refused;
		xfer && !host_is_cmd && !host_is_read && s_r.phase == PH_PARAM && s_r.cmd == CMD_IF &&
			s_r.pidx == 3'h0 && hb[1:0] == MODE_BAD_LOW |=> $stable(transfer_mode) && if_setting_refused;
	endproperty
	a_if_refused: assert property (p_if_refused) else $error("bad mode accepted");

	property p_buf_no_loss;
		rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
	endproperty
	a_buf_no_loss: assert property (p_buf_no_loss) else $error("read word lost");
endmodule

//--- verification/rgb_source.sv
// Behavioural RGB video source driving the display interface inputs
`timescale 1ns/1ps
module rgb_source
	import ram_cmd_pkg::*;
#(
	parameter logic [17:0] BASE = 18'h15A00
) (
	// Clock and control from the bench
	input wire logic sys_clk,
	input wire logic run,
	input wire logic frame,
	input wire logic line,
	// Video lines towards the device
	output logic pixel_clock,
	output logic data_enable,
	output logic line_sync_input,
	output logic frame_sync_input,
	output logic [ram_cmd_pkg::PIX_W-1:0] rgb_data
);
	// ==========================================================
	// Pixel clock and data
	logic [1:0] ph_r = 2'h0;
	logic clk_r = 1'b0;
	logic [17:0] n_r = 18'h00000;
	// Clock stands still between bursts; data changes mid-way through the high level,
	// away from both sampling edges
	always_ff @(posedge sys_clk) begin
		ph_r <= run ? ph_r + 2'h1 : 2'h0;
		if (!run) begin
			clk_r <= 1'b0;
		end else if (ph_r == 2'h3) begin
			clk_r <= ~clk_r;
		end else if (ph_r == 2'h1 && clk_r) begin
			n_r <= n_r + 18'h00001;
		end
	end
	assign pixel_clock = clk_r;
	// Idle data shows the inverse so no stale pixel can pass for a fresh one
	assign rgb_data = run ? BASE + n_r : ~(BASE + n_r);
	assign data_enable = run;
	assign line_sync_input = line;
	assign frame_sync_input = frame;
endmodule

//--- verification/test_display_ram_access_scroll_partial_cmds.sv
// Self-checking bench for the display RAM command interpreter
`timescale 1ns/1ps
module test_display_ram_access_scroll_partial_cmds;
	import ram_cmd_pkg::*;
	// ==========================================================
	// Signals
	logic sys_clk = 1'b0, rst_n = 1'b0, host_valid = 1'b0, host_is_cmd = 1'b0, line = 1'b0;
	logic host_is_read = 1'b0, rd_ready = 1'b0, frame_start = 1'b0, run = 1'b0, frame = 1'b0;
	logic [17:0] host_wdata = 18'h00000;
	logic host_ready, rd_valid, pixel_clock, data_enable, line_sync_input, frame_sync_input;
	logic [17:0] rd_data, rgb_data;
	logic divided_clock_tick, scroll_active, partial_on, nondisplay_refresh, nondisplay_hiz;
	logic [7:0] scroll_start, scroll_end, scroll_lines_eff, display_start_line;
	logic [7:0] partial_start, partial_end;
	logic [1:0] scroll_mode, rgb_width;
	logic nondisplay_drive_select, clock_edge_select, data_enable_polarity, sync_polarity;
	logic [2:0] transfer_mode, pixel_clock_div;
	logic if_setting_refused;
	logic [19:0] nref, ticks;
	logic [2:0] md [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h7};
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	always #10 sys_clk = ~sys_clk;
	ram_cmd_ctrl u_dut (.sys_clk, .rst_n, .host_valid, .host_ready, .host_is_cmd, .host_is_read,
		.host_wdata, .rd_valid, .rd_ready, .rd_data, .pixel_clock, .data_enable,
		.line_sync_input, .frame_sync_input, .rgb_data, .frame_start, .divided_clock_tick,
		.scroll_start, .scroll_end, .scroll_lines_eff, .scroll_mode, .display_start_line,
		.scroll_active, .partial_on, .partial_start, .partial_end, .nondisplay_refresh,
		.nondisplay_hiz, .nondisplay_drive_select, .transfer_mode, .clock_edge_select,
		.rgb_width, .data_enable_polarity, .sync_polarity, .pixel_clock_div, .if_setting_refused);
	rgb_source u_src (.sys_clk, .run, .frame, .line, .pixel_clock, .data_enable, .line_sync_input,
		.frame_sync_input, .rgb_data);
	// ==========================================================
	// Access tasks
	task automatic tally_and_finish();
		$display("compares=%0d mismatches=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic c, input logic r, input logic [17:0] d);
		int n = 0;
		@(negedge sys_clk);
		host_valid = 1'b1;
		host_is_cmd = c;
		host_is_read = r;
		host_wdata = d;
		while (host_ready !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		chk(host_ready, 1'b1);
		@(posedge sys_clk);
		@(negedge sys_clk);
		host_valid = 1'b0;
	endtask
	task automatic send(input logic [7:0] c, input int n, input logic [7:0] a = 8'h00,
		input logic [7:0] b = 8'h00, input logic [7:0] d = 8'h00, input logic [7:0] e = 8'h00);
		logic [7:0] p [4] = '{a, b, d, e};
		xfer(1'b1, 1'b0, {10'h000, c});
		for (int i = 0; i < n; i++) begin
			xfer(1'b0, 1'b0, {10'h000, p[i]});
		end
		@(negedge sys_clk);
	endtask
	task automatic rdq();
		xfer(1'b0, 1'b1, 18'h00000);
	endtask
	task automatic pop(input logic [17:0] exp);
		int n = 0;
		while (rd_valid !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		chk({rd_valid, rd_data}, {1'b1, exp});
		rd_ready = 1'b1;
		@(negedge sys_clk);
		rd_ready = 1'b0;
	endtask
	task automatic fr();
		@(negedge sys_clk);
		frame_start = 1'b1;
		@(negedge sys_clk);
		frame_start = 1'b0;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (divided_clock_tick === 1'b1)
			ticks <= ticks + 20'h00001;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	// ==========================================================
	// Tests
	initial begin
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		send(CMD_START_ADDR, 2, 8'h02, 8'h01);
		send(CMD_END_ADDR, 2, 8'h03, 8'h02);
		send(CMD_WRITE, 0);
		for (int i = 0; i < 5; i++) begin
			xfer(1'b0, 1'b0, 18'h00100 + i);
		end
		send(CMD_READ, 0);
		for (int i = 0; i < 5; i++) begin
			rdq();
			pop((i % 4 == 0) ? 18'h00104 : 18'h00100 + i);
		end
		$display("test stream finished");
		send(CMD_RMW, 0);
		rdq();
		pop(18'h00104);
		rdq();
		pop(18'h00104);
		xfer(1'b0, 1'b0, 18'h001F0);
		rdq();
		pop(18'h00101);
		xfer(1'b0, 1'b0, 18'h001F1);
		send(CMD_READ, 0);
		rdq();
		pop(18'h001F0);
		rdq();
		pop(18'h001F1);
		rdq();
		rdq();
		@(negedge sys_clk);
		chk(host_ready, 1'b0);
		pop(18'h00102);
		pop(18'h00103);
		chk(rd_valid, 1'b0);
		$display("test read_modify_write finished");
		send(CMD_SCROLL, 4, 8'h10, 8'hD3, 8'hD3, 8'h00);
		chk(display_start_line, 8'h10);
		chk(scroll_active, 1'b0);
		chk({scroll_start, scroll_end}, 16'h10D3);
		send(CMD_START_LINE, 1, 8'h28);
		chk({scroll_active, display_start_line}, 9'h128);
		send(CMD_START_LINE, 1, 8'h29);
		chk(display_start_line, 8'h29);
		for (int m = 0; m < 4; m++) begin
			send(CMD_SCROLL, 4, 8'h00, 8'hDB, 8'h64, m[7:0]);
			chk(scroll_mode, m[1:0]);
			chk(scroll_lines_eff, m[1] ? 8'h00 : 8'h64);
		end
		$display("test scroll finished");
		send(CMD_PART_IN, 3, 8'h03, 8'h0E, 8'h81);
		fr();
		chk({partial_on, partial_start, partial_end}, 17'h1030E);
		chk(nondisplay_drive_select, 1'b1);
		nref = 20'h00000;
		repeat (6) begin
			fr();
			nref = nref + nondisplay_refresh;
			chk(nondisplay_hiz, !nondisplay_refresh);
		end
		chk(nref, 20'h00002);
		send(CMD_PART_IN, 3, 8'h00, 8'h09, 8'h7F);
		fr();
		chk(nondisplay_drive_select, 1'b0);
		repeat (3) begin
			fr();
			chk({nondisplay_refresh, nondisplay_hiz}, 2'h1);
		end
		send(CMD_PART_OUT, 0);
		chk(partial_on, 1'b1);
		fr();
		chk({partial_on, nondisplay_hiz}, 2'h0);
		$display("test partial finished");
		for (int i = 0; i < 6; i++) begin
			send(CMD_IF, 2, {i[2], i[1], 2'(i % 3), i[0], md[i]}, i[7:0]);
			chk({transfer_mode, clock_edge_select, rgb_width, data_enable_polarity, sync_polarity},
				{md[i], i[0], 2'(i % 3), i[1], i[2]});
			chk({if_setting_refused, pixel_clock_div}, {1'b0, i[2:0]});
		end
		send(CMD_IF, 2, 8'h06, 8'h07);
		chk({if_setting_refused, transfer_mode, pixel_clock_div}, {1'b1, 3'h7, 3'h7});
		send(CMD_IF, 2, 8'h30, 8'h06);
		chk({if_setting_refused, rgb_width}, 3'h6);
		$display("test interface finished");
		send(CMD_IF, 2, 8'hC4, 8'h02);
		repeat (4) @(negedge sys_clk);
		frame = 1'b1;
		repeat (4) @(negedge sys_clk);
		frame = 1'b0;
		ticks = 20'h00000;
		run = 1'b1;
		repeat (2) @(posedge pixel_clock);
		repeat (3) @(negedge sys_clk);
		// Line start between edges two and three restarts the divider
		line = 1'b1;
		@(negedge sys_clk);
		line = 1'b0;
		repeat (4) @(posedge pixel_clock);
		repeat (6) @(negedge sys_clk);
		run = 1'b0;
		chk(ticks, 20'h00001);
		// Falling edge, 6-bit steps: one pixel from three steps at address 0
		send(CMD_IF, 2, 8'hEC, 8'h00);
		frame = 1'b1;
		@(negedge sys_clk);
		frame = 1'b0;
		run = 1'b1;
		repeat (3) @(negedge pixel_clock);
		repeat (2) @(negedge sys_clk);
		run = 1'b0;
		send(CMD_IF, 2, 8'hC1, 8'h00);
		send(CMD_START_ADDR, 2, 8'h00, 8'h00);
		send(CMD_END_ADDR, 2, COL_MAX, ROW_MAX);
		send(CMD_READ, 0);
		for (int i = 0; i < 3; i++) begin
			rdq();
			pop((i == 0) ? 18'h07209 : 18'h15A00 + i);
		end
		$display("test rgb finished");
		tally_and_finish();
	end
endmodule
